// >>> design/exp_trig_ctrl.sv
// Exposure trigger and amplifier power-down controller with Wishbone registers
//
// Overview of operation
// - Mode 0 starts each exposure automatically as soon as readout allows; trigger pin ignored.
// - In mode 0 on a CCD in a sequence the next exposure starts together with sensor readout.
// - Mode 1 starts an exposure only on a software force command.
// - Mode 2 runs delay then exposure from a trigger edge whose polarity a switch selects.
// - Mode 3 ignores programmed delay and exposes for the trigger pulse length, or for the programmed exposure when forced.
// - Mode 3 in double-image operation exposes the second image during first readout.
// - In modes 2 and 3 trigger edges count only when acquire mode and acquire-enable allow.
// - A software force trigger always acts, whatever the acquire-enable level.
// - A max-rate control enables the longest exposure at the maximum frame rate.
// - In max-rate mode exposure is derived from vertical ROI and line time, reported in ns.
// - The sensor output amplifier is switched off during long exposures.
// - With user select low the power-down uses a fixed internal preset delay.
// - With user select high the amplifier powers down after the user-programmed time.
// - A capability bit reports whether user-timed power-down is supported.
`timescale 1ns/1ps
`include "exp_trig_params.svh"
module exp_trig_ctrl
  import exp_trig_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter bit          USER_SLEEP_OK = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        exp_trig_i,
  input  wire logic        acq_enbl_i,
  input  wire logic        trig_polarity_i,
  input  wire logic        acquire_gate_i,
  input  wire logic        double_image_i,
  input  wire logic        ccd_sensor_i,
  input  wire logic        readout_done_i,
  output logic             exposure_o,
  output logic             readout_start_o,
  output logic             amp_sleep_o
);
  import exp_trig_pkg::*;

  // Registers
  trig_mode_t  trigger_select;
  logic        max_rate_exposure_enable;
  logic        amp_sleep_user_select;
  logic [15:0] amp_sleep_delay_ms;
  logic [31:0] exposure_ns;
  logic [31:0] delay_ns;
  logic [15:0] roi_lines;
  logic [15:0] line_ns;
  logic        bad_mode;
  logic        force_pend;
  logic        second_image;
  logic        forced_run;
  exp_state_t  state;
  exp_state_t  next_state;
  logic [31:0] phase_cnt;
  logic [31:0] max_rate_exposure_time;

  // Synchronised pins
  logic trig_level;
  logic trig_rise;
  logic trig_fall;
  logic acq_sync;
  logic pol_sync;
  logic gate_sync;
  logic dbl_sync;
  logic ccd_sync;
  logic rdone_sync;
  logic rdone_rise;

  edge_sync u_trig (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (exp_trig_i),
    .level_o   (trig_level),
    .rise_o    (trig_rise),
    .fall_o    (trig_fall)
  );

  edge_sync u_rdone (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (readout_done_i),
    .level_o   (rdone_sync),
    .rise_o    (rdone_rise),
    .fall_o    ()
  );

  // Slow straps and levels share one two-flop bank
  logic [4:0] strap_meta;
  logic [4:0] strap_sync;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_meta <= 5'h0;
      strap_sync <= 5'h0;
    end else begin
      strap_meta <= {ccd_sensor_i, double_image_i, acquire_gate_i, trig_polarity_i, acq_enbl_i};
      strap_sync <= strap_meta;
    end
  end
  assign acq_sync  = strap_sync[0];
  assign pol_sync  = strap_sync[1];
  assign gate_sync = strap_sync[2];
  assign dbl_sync  = strap_sync[3];
  assign ccd_sync  = strap_sync[4];

  // Bus decode
  function automatic logic hit(input logic [5:0] adr, input logic [3:0] idx);
    return adr == {2'b00, idx};
  endfunction

  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire mapped   = wb_adr_i <= {2'b00, `REG_LINE_NS};
  wire wr       = bus_req & wb_we_i & mapped;
  wire wr_lo    = wr & wb_sel_i[0];
  wire wr_lo16  = wr & wb_sel_i[0] & wb_sel_i[1];
  wire wr_all   = wr & (&wb_sel_i);
  wire mode_wr  = wr_all & hit(wb_adr_i, `REG_TRIG_SELECT);
  wire mode_ok  = wb_dat_i <= `TRIG_MAX_CODE;
  wire force_wr = wr_lo & hit(wb_adr_i, `REG_FORCE) & wb_dat_i[0];

  // Trigger qualification
  wire ext_mode   = (trigger_select == `TRIG_EDGE) | (trigger_select == `TRIG_PULSE);
  wire edge_allow = ext_mode & acq_sync & gate_sync;
  wire act_edge   = pol_sync ? trig_fall : trig_rise;
  wire act_level  = pol_sync ? ~trig_level : trig_level;
  wire act_end    = pol_sync ? trig_rise : trig_fall;
  wire ext_start  = edge_allow & act_edge;
  wire soft_start = force_pend;
  wire auto_start = (trigger_select == `TRIG_AUTO);

  // Max-rate exposure: lines times line time minus fixed overhead
  wire [31:0] frame_ns = 32'(roi_lines) * 32'(line_ns);
  always_comb begin
    max_rate_exposure_time = (frame_ns > `READOUT_OVERHEAD_NS) ?
                             frame_ns - `READOUT_OVERHEAD_NS : 32'h0;
  end
  wire [31:0] eff_exposure = max_rate_exposure_enable ? max_rate_exposure_time
                                                      : exposure_ns;

  wire [31:0] phase_ns     = phase_cnt * `CLK_PERIOD_NS;
  wire        delay_done   = phase_ns >= delay_ns;
  wire        expose_done  = phase_ns >= eff_exposure;
  wire        pulse_mode   = (trigger_select == `TRIG_PULSE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (soft_start)
          next_state = ST_DELAY;
        else if (ext_start && pulse_mode)
          next_state = ST_EXPOSE;
        else if (ext_start || auto_start)
          next_state = ST_DELAY;
      end
      ST_DELAY: begin
        if (delay_done || pulse_mode)
          next_state = ST_EXPOSE;
      end
      ST_EXPOSE: begin
        if (pulse_mode && !second_image && !forced_run && act_end)
          next_state = ST_READ;
        else if ((!pulse_mode || forced_run) && expose_done)
          next_state = ST_READ;
      end
      ST_READ: begin
        if (rdone_rise)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Auto mode on a CCD in a sequence overlaps the next exposure with readout
  wire overlap = auto_start & ccd_sync & (state == ST_READ);
  // Second image flag is already set while the first image reads out
  wire dbl_second = pulse_mode & dbl_sync & (state == ST_READ) & second_image;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state        <= ST_IDLE;
      phase_cnt    <= 32'h0;
      second_image <= 1'b0;
      forced_run   <= 1'b0;
    end else begin
      state     <= next_state;
      // Force pending clears on leaving idle, so remember it for the run
      if (state == ST_IDLE)
        forced_run <= soft_start;
      phase_cnt <= (next_state != state) ? 32'h0 : phase_cnt + 32'h1;
      if (next_state == ST_READ && state == ST_EXPOSE && pulse_mode && dbl_sync)
        second_image <= ~second_image;
      else if (state == ST_IDLE)
        second_image <= 1'b0;
    end
  end

  // Power-down timer runs while exposing
  wire [15:0] sleep_ms = amp_sleep_user_select ? amp_sleep_delay_ms
                                               : `AUTO_SLEEP_MS;
  logic sleep_due;
  ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_sleep (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (state == ST_EXPOSE),
    .delay_ms_i (sleep_ms),
    .expired_o  (sleep_due)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exposure_o      <= 1'b0;
      readout_start_o <= 1'b0;
      amp_sleep_o     <= 1'b0;
    end else begin
      exposure_o      <= (next_state == ST_EXPOSE) | overlap | dbl_second;
      readout_start_o <= (state == ST_EXPOSE) & (next_state == ST_READ);
      amp_sleep_o     <= (state == ST_EXPOSE) & sleep_due;
    end
  end

  // Register writes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trigger_select           <= `TRIG_AUTO;
      max_rate_exposure_enable <= 1'b0;
      amp_sleep_user_select    <= 1'b0;
      amp_sleep_delay_ms       <= 16'h0;
      exposure_ns              <= 32'h0;
      delay_ns                 <= 32'h0;
      roi_lines                <= 16'h0;
      line_ns                  <= 16'h0;
      bad_mode                 <= 1'b0;
      force_pend               <= 1'b0;
    end else begin
      if (mode_wr && mode_ok)
        trigger_select <= wb_dat_i[1:0];
      if (mode_wr)
        bad_mode <= ~mode_ok;
      if (force_wr)
        force_pend <= 1'b1;
      else if (state == ST_IDLE)
        force_pend <= 1'b0;
      if (wr_lo && hit(wb_adr_i, `REG_RATE_CTRL))
        max_rate_exposure_enable <= wb_dat_i[0];
      if (wr_lo && hit(wb_adr_i, `REG_SLEEP_CTRL))
        amp_sleep_user_select <= wb_dat_i[0] & USER_SLEEP_OK;
      if (wr_lo16 && hit(wb_adr_i, `REG_SLEEP_DELAY))
        amp_sleep_delay_ms <= wb_dat_i[15:0];
      if (wr_all && hit(wb_adr_i, `REG_EXPOSURE))
        exposure_ns <= wb_dat_i;
      if (wr_all && hit(wb_adr_i, `REG_DELAY))
        delay_ns <= wb_dat_i;
      if (wr_lo16 && hit(wb_adr_i, `REG_ROI_LINES))
        roi_lines <= wb_dat_i[15:0];
      if (wr_lo16 && hit(wb_adr_i, `REG_LINE_NS))
        line_ns <= wb_dat_i[15:0];
    end
  end

  // Read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i[3:0])
      `REG_TRIG_SELECT: rd_data = {30'h0, trigger_select};
      `REG_FORCE:       rd_data = {31'h0, force_pend};
      `REG_RATE_CTRL:   rd_data = {31'h0, max_rate_exposure_enable};
      `REG_RATE_TIME:   rd_data = max_rate_exposure_time;
      `REG_SLEEP_CTRL:  rd_data = {31'h0, amp_sleep_user_select};
      `REG_SLEEP_DELAY: rd_data = {16'h0, amp_sleep_delay_ms};
      `REG_EXPOSURE:    rd_data = exposure_ns;
      `REG_DELAY:       rd_data = delay_ns;
      `REG_STATUS: begin
        rd_data[`ST_BUSY_BIT]     = state != ST_IDLE;
        rd_data[`ST_EXPOSING_BIT] = exposure_o;
        rd_data[`ST_AMP_OFF_BIT]  = amp_sleep_o;
        rd_data[`ST_BAD_MODE_BIT] = bad_mode;
        rd_data[`ST_READING_BIT]  = state == ST_READ;
      end
      `REG_CAPS:        rd_data[`CAPS_USER_SLEEP_BIT] = USER_SLEEP_OK;
      `REG_ROI_LINES:   rd_data = {16'h0, roi_lines};
      `REG_LINE_NS:     rd_data = {16'h0, line_ns};
      default:          rd_data = 32'h0;
    endcase
  end

  // One-cycle ack; unmapped addresses answer with err
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req & mapped;
      wb_err_o <= bus_req & ~mapped;
      wb_dat_o <= (bus_req & mapped & ~wb_we_i) ? rd_data : 32'h0;
    end
  end
endmodule

// >>> include/exp_trig_params.svh
// Register offsets, trigger mode codes, field positions and timing counts
`ifndef EXP_TRIG_PARAMS_SVH
`define EXP_TRIG_PARAMS_SVH

`define REG_TRIG_SELECT     4'h0
`define REG_FORCE           4'h1
`define REG_RATE_CTRL       4'h2
`define REG_RATE_TIME       4'h3
`define REG_SLEEP_CTRL      4'h4
`define REG_SLEEP_DELAY     4'h5
`define REG_EXPOSURE        4'h6
`define REG_DELAY           4'h7
`define REG_STATUS          4'h8
`define REG_CAPS            4'h9
`define REG_ROI_LINES       4'ha
`define REG_LINE_NS         4'hb

`define TRIG_AUTO           2'h0
`define TRIG_SOFT           2'h1
`define TRIG_EDGE           2'h2
`define TRIG_PULSE          2'h3
`define TRIG_MAX_CODE       32'h00000003

`define ST_BUSY_BIT         0
`define ST_EXPOSING_BIT     1
`define ST_AMP_OFF_BIT      2
`define ST_BAD_MODE_BIT     3
`define ST_READING_BIT      4
`define CAPS_USER_SLEEP_BIT 0

`define CLK_PERIOD_NS       32'd25
`define CYCLES_PER_US       32'd40
`define CYCLES_PER_MS       32'd40000
`define AUTO_SLEEP_MS       16'd100
`define READOUT_OVERHEAD_NS 32'd1000

`endif

// >>> include/exp_trig_pkg.sv
// Types shared by the exposure trigger control block
package exp_trig_pkg;
  typedef logic [1:0] trig_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_EXPOSE = 4'b0100,
    ST_READ   = 4'b1000
  } exp_state_t;
endpackage

// >>> design/edge_sync.sv
// Two-flop synchroniser with edge detection for external pins
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~last;
  assign fall_o  = ~sync & last;
endmodule

// >>> design/ms_timer.sv
// Millisecond up-counter that flags expiry of a programmed delay
`timescale 1ns/1ps
`include "exp_trig_params.svh"
module ms_timer #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        run_i,
  input  wire logic [15:0] delay_ms_i,
  output logic             expired_o
);
  logic [31:0] tick;
  logic [15:0] ms_count;
  wire         ms_edge = (tick == CYCLES_PER_MS - 1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick      <= 32'h0;
      ms_count  <= 16'h0;
      expired_o <= 1'b0;
    end else if (!run_i) begin
      tick      <= 32'h0;
      ms_count  <= 16'h0;
      expired_o <= 1'b0;
    end else begin
      tick <= ms_edge ? 32'h0 : tick + 32'h1;
      if (ms_edge && !expired_o)
        ms_count <= ms_count + 16'h1;
      expired_o <= expired_o | (ms_count >= delay_ms_i);
    end
  end
endmodule

// >>> verif/exp_trig_ctrl_asserts.sv
// Port-level assertions for the exposure trigger controller
`timescale 1ns/1ps
module exp_trig_ctrl_asserts (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        exposure_o,
  input wire logic        readout_start_o,
  input wire logic        amp_sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_mapped;
    s_req ##0 (wb_adr_i <= 6'h0b);
  endsequence
  sequence s_unmapped;
    s_req ##0 (wb_adr_i > 6'h0b);
  endsequence
  a_bus_ack_next: assert property (s_mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked next cycle");
  a_err_unmapped: assert property (s_unmapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_one_resp: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_amp_in_exposure: assert property ($rose(amp_sleep_o) |-> exposure_o)
    else $error("amplifier off outside exposure");
  a_amp_wake_end: assert property ($fell(exposure_o) |-> ##[0:1] !amp_sleep_o)
    else $error("amplifier not woken at exposure end");
  a_rd_one_pulse: assert property (readout_start_o |=> !readout_start_o)
    else $error("readout start longer than one cycle");
  a_rd_after_exp: assert property (readout_start_o |-> $past(exposure_o))
    else $error("readout start without exposure");
endmodule
bind exp_trig_ctrl exp_trig_ctrl_asserts i_exp_trig_ctrl_asserts (.clk_i, .sys_rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .exposure_o,
  .readout_start_o, .amp_sleep_o);

// >>> verif/sensor_readout_model.sv
// Sensor readout model: ends each readout after a settable delay
`timescale 1ns/1ps
module sensor_readout_model (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic readout_start_i,
  input  wire logic [7:0] rd_cycles_i,
  output logic      readout_done_o
);
  logic [7:0] cnt;
  // Done pulses once per readout, never while idle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 8'h00;
      readout_done_o <= 1'b0;
    end else begin
      readout_done_o <= (cnt == 8'h01);
      if (readout_start_i) cnt <= rd_cycles_i;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
  end
endmodule

// >>> verif/tb_exp_trig_ctrl.sv
// Self-checking bench for the exposure trigger controller
`timescale 1ns/1ps
`include "exp_trig_params.svh"
module tb_exp_trig_ctrl;
  import exp_trig_pkg::*;
  localparam int CPMS = 40;
  logic        clk_i = 0, sys_rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [5:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dw = 0, wb_dat_o, rd;
  logic        wb_ack_o, wb_err_o, re, trig = 0, acq = 0, pol = 0;
  logic        exposure_o, readout_start_o, amp_sleep_o, done, slp;
  logic [15:0] rnd = 16'h49ba;
  logic [7:0]  rdc = 8'd6;
  int          err_count = 0, checks = 0, len;
  int          ue[4] = '{1, 1, 0, 0};
  int          xe[4] = '{3000, 500, 3000, 120000};
  exp_trig_ctrl #(.CYCLES_PER_MS(CPMS)) i_exp_trig_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .exp_trig_i(trig), .acq_enbl_i(acq), .trig_polarity_i(pol), .acquire_gate_i(1'b1),
    .double_image_i(1'b0), .ccd_sensor_i(1'b0), .readout_done_i(done),
    .exposure_o(exposure_o), .readout_start_o(readout_start_o), .amp_sleep_o(amp_sleep_o));
  sensor_readout_model i_sensor_readout_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .readout_start_i(readout_start_o), .rd_cycles_i(rdc), .readout_done_o(done));
  always #12.5 clk_i = ~clk_i;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] near(input int g, input int e);
    return 32'((g >= e - 1) && (g <= e + 1));
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("[ERR] %0t bus answer timed out", $time);
    end
    rd = wb_dat_o;
    re = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, {2'b00, a}, d, 4'hf);
  endtask
  task automatic rdr(input logic [3:0] a);
    wb(1'b0, {2'b00, a}, 32'h0, 4'hf);
  endtask
  // Waits for an exposure, then times it and notes any amplifier sleep
  task automatic meas(input int w);
    int n;
    n = 0;
    len = 0;
    slp = 0;
    while (exposure_o !== 1'b1 && n < w) begin
      @(posedge clk_i);
      n++;
    end
    while (exposure_o === 1'b1 && len < 9000) begin
      @(posedge clk_i);
      len++;
      if (amp_sleep_o === 1'b1) slp = 1;
    end
  endtask
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    conclude();
  end
  initial begin
    int i, r, l, e;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdr(`REG_CAPS);
    chk(rd, 32'h1);
    wb(1'b0, 6'h0c, 32'h0, 4'hf);
    chk(32'(re), 32'h1);
    wr(`REG_RATE_CTRL, 32'h1);
    for (i = 0; i < 3; i++) begin
      rnd = nxt(rnd);
      r = (i == 0) ? 2 : 2 + rnd[7:0];
      l = 100 + rnd[15:8];
      wr(`REG_ROI_LINES, r);
      wr(`REG_LINE_NS, l);
      rdr(`REG_RATE_TIME);
      chk(rd, (r * l > `READOUT_OVERHEAD_NS) ? r * l - `READOUT_OVERHEAD_NS : 0);
    end
    wr(`REG_RATE_CTRL, 32'h0);
    wr(`REG_DELAY, 32'h0);
    wr(`REG_EXPOSURE, 32'd200);
    wr(`REG_TRIG_SELECT, 32'h0);
    for (i = 0; i < 2; i++) begin
      meas(100);
      chk(near(len, 8), 32'h1);
    end
    wr(`REG_TRIG_SELECT, 32'h1);
    repeat (40) @(posedge clk_i);
    wr(`REG_TRIG_SELECT, 32'h4);
    rdr(`REG_TRIG_SELECT);
    chk(rd, 32'h1);
    rdr(`REG_STATUS);
    chk(32'(rd[`ST_BAD_MODE_BIT]), 32'h1);
    trig <= 1'b1;
    meas(30);
    chk(32'(len), 32'h0);
    trig <= 1'b0;
    wr(`REG_FORCE, 32'h1);
    meas(30);
    chk(near(len, 8), 32'h1);
    repeat (30) @(posedge clk_i);
    for (i = 0; i < 2; i++) begin
      rnd = nxt(rnd);
      e = 4 + rnd[3:0];
      rdc <= 8'd2 + rnd[7:4];
      pol <= i[0];
      trig <= i[0];
      acq <= 1'b1;
      wr(`REG_EXPOSURE, e * 25);
      wr(`REG_TRIG_SELECT, 32'h2);
      trig <= ~pol;
      meas(20);
      chk(near(len, e), 32'h1);
      trig <= pol;
      repeat (40) @(posedge clk_i);
      acq <= 1'b0;
      trig <= ~pol;
      meas(20);
      chk(32'(len), 32'h0);
      trig <= pol;
      acq <= 1'b1;
      wr(`REG_TRIG_SELECT, 32'h1);
    end
    wr(`REG_EXPOSURE, 32'd2000);
    wr(`REG_TRIG_SELECT, 32'h3);
    rnd = nxt(rnd);
    r = 5 + rnd[3:0];
    fork
      begin
        trig <= ~pol;
        repeat (r) @(posedge clk_i);
        trig <= pol;
      end
      meas(20);
    join
    chk(near(len, r), 32'h1);
    repeat (40) @(posedge clk_i);
    wr(`REG_TRIG_SELECT, 32'h1);
    wb(1'b1, {2'b00, `REG_SLEEP_DELAY}, 32'h1, 4'h3);
    for (i = 0; i < 4; i++) begin
      wr(`REG_SLEEP_CTRL, ue[i]);
      wr(`REG_EXPOSURE, xe[i]);
      wr(`REG_FORCE, 32'h1);
      meas(30);
      l = (ue[i] == 1) ? CPMS : `AUTO_SLEEP_MS * CPMS;
      chk(32'(slp), 32'(xe[i] / 25 >= l));
      repeat (40) @(posedge clk_i);
    end
    conclude();
  end
endmodule
